// >>> logic/uart_fmt_pkg.sv
// Shared constants, codes and carrier types for the status and line format block
package uart_fmt_pkg;

	// Register byte offsets on the bus
	localparam logic [3:0] OFS_IDENT = 4'h0;
	localparam logic [3:0] OFS_LINE = 4'h4;
	localparam logic [3:0] OFS_FIFO = 4'h8;

	// Line format control and FIFO setup field positions
	localparam int LINE_DIVISOR_BIT = 7;
	localparam int LINE_BREAK_BIT = 6;
	localparam int LINE_STICK_BIT = 5;
	localparam int LINE_EVEN_BIT = 4;
	localparam int LINE_PAR_EN_BIT = 3;
	localparam int LINE_STOP_BIT = 2;
	localparam int LINE_LEN_LSB = 0;
	localparam int FIFO_ENABLE_BIT = 0;

	// Identity register fields
	localparam int IDENT_FIFO_LSB = 6;
	localparam logic [1:0] IDENT_FIFO_ON = 2'h3;
	localparam logic [1:0] IDENT_FIFO_OFF = 2'h0;
	localparam logic [1:0] IDENT_UNUSED = 2'h0;

	// Codes shown in identity bits 3:0
	localparam logic [3:0] CODE_LINE = 4'h6;
	localparam logic [3:0] CODE_RX_AVAIL = 4'h4;
	localparam logic [3:0] CODE_RX_TIMEOUT = 4'hc;
	localparam logic [3:0] CODE_TX_EMPTY = 4'h2;
	localparam logic [3:0] CODE_MODEM = 4'h0;
	localparam logic [3:0] CODE_NONE = 4'h1;

	// Reset values
	localparam logic [7:0] LINE_RESET = 8'h00;
	localparam logic FIFO_RESET = 1'b0;
	localparam logic TX_IDLE = 1'b1;

	// Character framing figures
	localparam logic [3:0] WORD_BITS_MIN = 4'h5;
	localparam logic [2:0] STOP_HALVES_ONE = 3'h2;
	localparam logic [2:0] STOP_HALVES_ONE_HALF = 3'h3;
	localparam logic [2:0] STOP_HALVES_TWO = 3'h4;

	// Bus phase, one-hot
	typedef enum logic [1:0] {
		BUS_IDLE = 2'b01,
		BUS_ACK = 2'b10
	} bus_phase_t;

	// Source currently reported, one-hot
	typedef enum logic [5:0] {
		SRC_NONE = 6'b000001,
		SRC_LINE = 6'b000010,
		SRC_RX_AVAIL = 6'b000100,
		SRC_RX_TIMEOUT = 6'b001000,
		SRC_TX_EMPTY = 6'b010000,
		SRC_MODEM = 6'b100000
	} src_sel_t;

	// Pending interrupt conditions from the rest of the channel
	typedef struct packed {
		logic line_status;
		logic rx_avail;
		logic rx_timeout;
		logic tx_empty;
		logic modem;
	} irq_src_t;

	// Character format handed to transmitter and receiver
	typedef struct packed {
		logic [3:0] word_bits;
		logic [2:0] stop_halves;
		logic parity_en;
		logic parity_bit;
		logic divisor_access;
	} line_fmt_t;

endpackage

// >>> logic/char_framer.sv
// Decodes line format control into word length, stop length and parity bit
`timescale 1ns/10ps
module char_framer (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [7:0] line,
	input wire logic [7:0] tx_char,
	output uart_fmt_pkg::line_fmt_t fmt
);

	uart_fmt_pkg::line_fmt_t fmt_d;
	uart_fmt_pkg::line_fmt_t fmt_q;
	logic [1:0] len;
	logic [7:0] mask;
	logic ones;

	// Decode the format fields
	always_comb begin
		len = line[uart_fmt_pkg::LINE_LEN_LSB +: 2];
		mask = 8'hff >> (3'h3 - {1'b0, len}); // Bits beyond word length ignored
		ones = ^(tx_char & mask);
		fmt_d = '0;
		fmt_d.word_bits = uart_fmt_pkg::WORD_BITS_MIN + {2'h0, len}; // [R16]
		if (!line[uart_fmt_pkg::LINE_STOP_BIT]) begin
			fmt_d.stop_halves = uart_fmt_pkg::STOP_HALVES_ONE; // [R15]
		end else if (len == 2'h0) begin
			fmt_d.stop_halves = uart_fmt_pkg::STOP_HALVES_ONE_HALF; // [R15]
		end else begin
			fmt_d.stop_halves = uart_fmt_pkg::STOP_HALVES_TWO; // [R15]
		end
		fmt_d.parity_en = line[uart_fmt_pkg::LINE_PAR_EN_BIT]; // [R13]
		// Stick codes follow customary practice, not the overlapping printed one
		case ({line[uart_fmt_pkg::LINE_STICK_BIT], line[uart_fmt_pkg::LINE_EVEN_BIT]})
			2'b00: fmt_d.parity_bit = ~ones; // [R14]
			2'b01: fmt_d.parity_bit = ones; // [R14]
			2'b10: fmt_d.parity_bit = 1'b1; // [R19]
			2'b11: fmt_d.parity_bit = 1'b0; // [R14]
			default: fmt_d.parity_bit = 1'b0;
		endcase
		if (!fmt_d.parity_en) begin
			fmt_d.parity_bit = 1'b0;
		end
		fmt_d.divisor_access = line[uart_fmt_pkg::LINE_DIVISOR_BIT]; // [R11]
	end

	// Register the decoded format
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			fmt_q <= '0;
		end else begin
			fmt_q <= fmt_d;
		end
	end

	assign fmt = fmt_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_word_len: assert property ($past(reset_n) |-> fmt.word_bits == 4'h5 + {2'h0, $past(line[1:0])}) // [R16]
		else $error("word length does not match control");
	a_stop_len: assert property ($past(reset_n) && $past(line[2]) // [R15]
		&& $past(line[1:0]) != 2'h0 |-> fmt.stop_halves == 3'h4)
		else $error("two stop bits expected");
	a_no_parity: assert property ($past(reset_n) && !$past(line[3]) |-> !fmt.parity_en) // [R13]
		else $error("parity enabled without control bit");
	a_force_one: assert property ($past(reset_n) && $past(line[5:3]) == 3'h5 |-> fmt.parity_bit) // [R19]
		else $error("forced parity one not produced");

endmodule

// >>> logic/uart_status_format.sv
// Interrupt identity and line format registers of one channel, Avalon-MM slave
// Behaviour
// R1 - Identity read returns the highest-priority pending interrupt code.
// R2 - A reported interrupt holds the identity until serviced; others wait.
// R3 - After servicing, the next lower pending interrupt shows on re-read.
// R4 - Line status interrupt: priority 1, code 0110.
// R5 - Received data available: priority 2, code 0100.
// R6 - Receive time-out: priority 2, code 1100.
// R7 - Transmit holding empty: priority 3, code 0010.
// R8 - Modem status: lowest priority 4, code 0000.
// R9 - Bit 0 reads 0 while pending, 1 when none; 1 after reset.
// R10 - Bits 7:6 read 11 with FIFOs enabled, 00 otherwise; reset 00.
// R11 - Line control bit 7 enables divisor latch access; resets clear.
// R12 - Line control bit 6 holds transmit output low until cleared.
// R13 - Bits 5:3 select parity; bit 3 clear means no parity bit.
// R14 - Bit 3 set: odd when bit 4 is 0, even 01, forced 0 at 11. Code forces 1 at 10 instead (R19).
// R15 - Bit 2 clear one stop; set gives 1.5 for 5 bits, else 2.
// R16 - Bits 1:0 select 5, 6, 7 or 8 bit characters.
// R17 - FIFO-enabled indication follows the FIFO setup enable bit.
// R18 - Identity bits 5:4 read zero.
// R19 - Parity bits 5:4 equal to 10 with bit 3 force parity one.
// R20 - All line control bits reset to zero.
//
// The implementer's own choices: the Avalon-MM slave port and the placing of the registers.
`timescale 1ns/10ps
module uart_status_format #(
	parameter int ADDR_W = 4
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic [ADDR_W-1:0] address,
	input wire logic read,
	input wire logic write,
	input wire logic [3:0] byteenable,
	input wire logic [31:0] writedata,
	output logic [31:0] readdata,
	output logic waitrequest,
	input wire uart_fmt_pkg::irq_src_t irq_src,
	input wire logic tx_serial,
	input wire logic [7:0] tx_char,
	output logic tx_line,
	output uart_fmt_pkg::line_fmt_t fmt
);

	// Elaboration check: the map needs byte offsets up to 8
	if (ADDR_W < 4) begin : g_addr_check
		$error("ADDR_W must be at least 4");
	end

	typedef struct packed {
		uart_fmt_pkg::bus_phase_t phase;
		logic [31:0] rdata;
		logic [7:0] line;
		logic fifo_on;
		uart_fmt_pkg::src_sel_t held;
		logic tx_line;
	} state_t;

	state_t st_q;
	state_t st_d;
	// Decode results feeding the next-state logic
	uart_fmt_pkg::src_sel_t top_src;
	logic held_live;
	logic [3:0] code;
	logic [7:0] ident;
	logic req;
	logic [3:0] word_addr;

	// Highest pending source; data available wins a tie with time-out
	always_comb begin
		if (irq_src.line_status) begin
			top_src = uart_fmt_pkg::SRC_LINE; // [R4]
		end else if (irq_src.rx_avail) begin
			top_src = uart_fmt_pkg::SRC_RX_AVAIL; // [R5]
		end else if (irq_src.rx_timeout) begin
			top_src = uart_fmt_pkg::SRC_RX_TIMEOUT; // [R6]
		end else if (irq_src.tx_empty) begin
			top_src = uart_fmt_pkg::SRC_TX_EMPTY; // [R7]
		end else if (irq_src.modem) begin
			top_src = uart_fmt_pkg::SRC_MODEM; // [R8]
		end else begin
			top_src = uart_fmt_pkg::SRC_NONE;
		end
	end

	// Whether the reported source is still awaiting service
	always_comb begin
		case (st_q.held)
			uart_fmt_pkg::SRC_LINE: held_live = irq_src.line_status;
			uart_fmt_pkg::SRC_RX_AVAIL: held_live = irq_src.rx_avail;
			uart_fmt_pkg::SRC_RX_TIMEOUT: held_live = irq_src.rx_timeout;
			uart_fmt_pkg::SRC_TX_EMPTY: held_live = irq_src.tx_empty;
			uart_fmt_pkg::SRC_MODEM: held_live = irq_src.modem;
			default: held_live = 1'b0;
		endcase
	end

	// Code for the reported source
	always_comb begin
		case (st_q.held)
			uart_fmt_pkg::SRC_LINE: code = uart_fmt_pkg::CODE_LINE; // [R4]
			uart_fmt_pkg::SRC_RX_AVAIL: code = uart_fmt_pkg::CODE_RX_AVAIL; // [R5]
			uart_fmt_pkg::SRC_RX_TIMEOUT: code = uart_fmt_pkg::CODE_RX_TIMEOUT; // [R6]
			uart_fmt_pkg::SRC_TX_EMPTY: code = uart_fmt_pkg::CODE_TX_EMPTY; // [R7]
			uart_fmt_pkg::SRC_MODEM: code = uart_fmt_pkg::CODE_MODEM; // [R8]
			default: code = uart_fmt_pkg::CODE_NONE; // [R9]
		endcase
	end

	// Identity register image
	always_comb begin
		ident = {(st_q.fifo_on ? uart_fmt_pkg::IDENT_FIFO_ON : uart_fmt_pkg::IDENT_FIFO_OFF), // [R10] [R17]
			uart_fmt_pkg::IDENT_UNUSED, code}; // [R18] [R1]
	end

	// Only address bits 3:0 are decoded, so a wider bus sees the map aliased
	assign req = read | write;
	assign word_addr = address[3:0];
	// One wait state on every access; answer is combinational from the phase
	assign waitrequest = req & (st_q.phase != uart_fmt_pkg::BUS_ACK);

	// Next state of the whole block
	always_comb begin
		st_d = st_q;
		// Bus phase: first cycle waits, second completes the access
		case (st_q.phase)
			uart_fmt_pkg::BUS_IDLE: begin
				if (req) begin
					st_d.phase = uart_fmt_pkg::BUS_ACK;
				end
			end
			uart_fmt_pkg::BUS_ACK: begin
				st_d.phase = uart_fmt_pkg::BUS_IDLE;
			end
			default: begin
				st_d.phase = uart_fmt_pkg::BUS_IDLE;
			end
		endcase
		// Read data is sampled while the master is still waiting
		if (read && st_q.phase == uart_fmt_pkg::BUS_IDLE) begin
			case (word_addr)
				uart_fmt_pkg::OFS_IDENT: st_d.rdata = {24'h000000, ident}; // [R1]
				uart_fmt_pkg::OFS_LINE: st_d.rdata = {24'h000000, st_q.line};
				uart_fmt_pkg::OFS_FIFO: st_d.rdata = {31'h00000000, st_q.fifo_on};
				default: st_d.rdata = 32'h00000000; // Unmapped reads as zero
			endcase
		end
		// Writes land at the completing edge; unmapped writes are dropped
		if (write && st_q.phase == uart_fmt_pkg::BUS_ACK && byteenable[0]) begin
			case (word_addr)
				uart_fmt_pkg::OFS_LINE: st_d.line = writedata[7:0]; // [R11] [R13] [R15] [R16]
				uart_fmt_pkg::OFS_FIFO: st_d.fifo_on = writedata[uart_fmt_pkg::FIFO_ENABLE_BIT]; // [R17]
				default: st_d.line = st_q.line;
			endcase
		end
		// Reported source is kept until serviced, then the next one takes over
		if (!held_live) begin
			st_d.held = top_src; // [R2] [R3]
		end
		// Break forces the line low for as long as the bit stays set
		st_d.tx_line = st_q.line[uart_fmt_pkg::LINE_BREAK_BIT] ? 1'b0 : tx_serial; // [R12]
	end

	// Register the state
	always_ff @(posedge clk) begin
		if (!reset_n) begin
			st_q.phase <= uart_fmt_pkg::BUS_IDLE;
			st_q.rdata <= 32'h00000000;
			st_q.line <= uart_fmt_pkg::LINE_RESET; // [R20]
			st_q.fifo_on <= uart_fmt_pkg::FIFO_RESET; // [R10]
			st_q.held <= uart_fmt_pkg::SRC_NONE; // [R9]
			st_q.tx_line <= uart_fmt_pkg::TX_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	// Data outputs come straight from flip-flops
	assign readdata = st_q.rdata;
	assign tx_line = st_q.tx_line;

	// Format decode and parity generation
	char_framer u_framer (
		.clk(clk),
		.reset_n(reset_n),
		.line(st_q.line),
		.tx_char(tx_char),
		.fmt(fmt)
	);

	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);

	a_code_line: assert property (st_q.held == uart_fmt_pkg::SRC_LINE |-> ident[3:0] == 4'h6) // [R4]
		else $error("line status code wrong");
	a_code_rx: assert property (st_q.held == uart_fmt_pkg::SRC_RX_AVAIL |-> ident[3:0] == 4'h4) // [R5]
		else $error("data available code wrong");
	a_code_timeout: assert property (st_q.held == uart_fmt_pkg::SRC_RX_TIMEOUT // [R6]
		|-> ident[3:0] == 4'hc)
		else $error("time-out code wrong");
	a_code_empty: assert property (st_q.held == uart_fmt_pkg::SRC_TX_EMPTY // [R7]
		|-> ident[3:0] == 4'h2)
		else $error("transmit empty code wrong");
	a_code_modem: assert property (st_q.held == uart_fmt_pkg::SRC_MODEM |-> ident[3:0] == 4'h0) // [R8]
		else $error("modem code wrong");
	a_line_first: assert property (st_q.held == uart_fmt_pkg::SRC_NONE // [R1]
		&& irq_src.line_status |=> st_q.held == uart_fmt_pkg::SRC_LINE)
		else $error("line status not taken first");
	a_held_stays: assert property (st_q.held == uart_fmt_pkg::SRC_MODEM // [R2]
		&& irq_src.modem |=> st_q.held == uart_fmt_pkg::SRC_MODEM)
		else $error("serviced-pending source replaced");
	a_next_lower: assert property (st_q.held == uart_fmt_pkg::SRC_LINE // [R3]
		&& !irq_src.line_status && !irq_src.rx_avail && !irq_src.rx_timeout
		&& irq_src.tx_empty |=> st_q.held == uart_fmt_pkg::SRC_TX_EMPTY)
		else $error("lower source not shown after service");
	a_none_flag: assert property (ident[0] == (st_q.held == uart_fmt_pkg::SRC_NONE)) // [R9]
		else $error("no-interrupt flag wrong");
	a_fifo_bits: assert property (ident[7:6] == {2{st_q.fifo_on}} && ident[5:4] == 2'h0) // [R10]
		else $error("fifo indication bits wrong");
	a_fifo_follow: assert property (write && !waitrequest && address[3:0] == 4'h8 && byteenable[0]
		|=> st_q.fifo_on == $past(writedata[0])) // [R17]
		else $error("fifo indication does not follow setup");
	a_break_low: assert property (st_q.line[6] [*2] |-> !tx_line) // [R12]
		else $error("break not holding line low");
	a_reset_line: assert property ($rose(reset_n) |-> st_q.line == 8'h00 && !fmt.divisor_access) // [R20]
		else $error("line control not cleared by reset");
	a_read_answer: assert property (read && st_q.phase == uart_fmt_pkg::BUS_IDLE // [R1]
		|=> !waitrequest || !read)
		else $error("read not answered after one wait");

	// Bus timing: one wait state, then the phase falls back to idle
	a_first_wait: assert property (req && st_q.phase == uart_fmt_pkg::BUS_IDLE // [R1]
		|-> waitrequest)
		else $error("access answered without its wait state");
	a_ack_once: assert property (st_q.phase == uart_fmt_pkg::BUS_ACK // [R1]
		|=> st_q.phase == uart_fmt_pkg::BUS_IDLE)
		else $error("completing phase lasted more than one cycle");

	// Read data stands at the edge where the master sees the answer
	a_ident_read: assert property (read && !waitrequest && address[3:0] == 4'h0 // [R1]
		|-> readdata == {24'h000000, $past(ident)})
		else $error("identity read data wrong");
	a_ident_spare: assert property (read && !waitrequest && address[3:0] == 4'h0 // [R18]
		|-> readdata[5:4] == 2'h0)
		else $error("unused identity bits not zero");
	a_line_read: assert property (read && !waitrequest && address[3:0] == 4'h4 // [R11]
		|-> readdata == {24'h000000, $past(st_q.line)})
		else $error("line control read data wrong");
	a_fifo_read: assert property (read && !waitrequest && address[3:0] == 4'h8 // [R17]
		|-> readdata == {31'h00000000, $past(st_q.fifo_on)})
		else $error("fifo setup read data wrong");
	a_unmapped_rd: assert property (read && !waitrequest && address[3:0] == 4'hc // [R1]
		|-> readdata == 32'h00000000)
		else $error("unmapped read not zero");

	// Writes land only when mapped, writable and lane 0 is enabled
	a_line_write: assert property (write && !waitrequest && address[3:0] == 4'h4 // [R11]
		&& byteenable[0] |=> st_q.line == $past(writedata[7:0]))
		else $error("line control write lost");
	a_lane_guard: assert property (write && !waitrequest && !byteenable[0] // [R20]
		|=> $stable(st_q.line) && $stable(st_q.fifo_on))
		else $error("write with lane 0 disabled took effect");
	a_ident_ro: assert property (write && !waitrequest && address[3:0] == 4'h0 // [R1]
		|=> $stable(st_q.line) && $stable(st_q.fifo_on))
		else $error("identity write changed a register");
	a_unmapped_wr: assert property (write && !waitrequest && address[3:0] == 4'hc // [R11]
		|=> $stable(st_q.line) && $stable(st_q.fifo_on))
		else $error("unmapped write changed a register");

	// Values seen in the first cycle out of reset
	a_reset_ident: assert property ($rose(reset_n) // [R9]
		|-> st_q.held == uart_fmt_pkg::SRC_NONE && !st_q.fifo_on && tx_line)
		else $error("identity or pin not at reset value");

	// Choice of the next source once the reported one is serviced
	a_none_next: assert property (irq_src == '0 // [R9]
		|=> st_q.held == uart_fmt_pkg::SRC_NONE)
		else $error("source reported with nothing pending");
	a_rx_level: assert property (!held_live && !irq_src.line_status && irq_src.rx_avail // [R5]
		|=> st_q.held == uart_fmt_pkg::SRC_RX_AVAIL)
		else $error("data available not chosen at level 2");
	a_timeout_level: assert property (!held_live && irq_src.rx_timeout // [R6]
		&& !irq_src.line_status && !irq_src.rx_avail
		|=> st_q.held == uart_fmt_pkg::SRC_RX_TIMEOUT)
		else $error("time-out not chosen at level 2");
	a_empty_level: assert property (!held_live && irq_src.tx_empty // [R7]
		&& !irq_src.line_status && !irq_src.rx_avail && !irq_src.rx_timeout
		|=> st_q.held == uart_fmt_pkg::SRC_TX_EMPTY)
		else $error("transmit empty not chosen at level 3");
	a_modem_level: assert property (!held_live && irq_src == 5'h01 // [R8]
		|=> st_q.held == uart_fmt_pkg::SRC_MODEM)
		else $error("modem not chosen when alone");
	a_held_onehot: assert property ($onehot(st_q.held)) // [R2]
		else $error("reported source not one-hot");
	a_held_keep: assert property (st_q.held != uart_fmt_pkg::SRC_NONE && held_live // [R2]
		|=> st_q.held == $past(st_q.held))
		else $error("pending source replaced before service");
	a_code_pending: assert property (st_q.held != uart_fmt_pkg::SRC_NONE // [R9]
		|-> !ident[0])
		else $error("pending flag not low");

	// Transmit pin follows the transmitter unless a break is set
	a_pass_through: assert property (!st_q.line[6] // [R12]
		|=> tx_line == $past(tx_serial))
		else $error("serial pin does not follow transmitter");
	a_break_next: assert property (st_q.line[6] // [R12]
		|=> !tx_line)
		else $error("break not applied one edge later");

endmodule

// >>> sim/avalon_host.sv
// Avalon-MM host model issuing one register access at a time
`timescale 1ns/10ps
module avalon_host (
	input wire logic clk,
	input wire logic waitrequest,
	output logic [3:0] address,
	output logic read,
	output logic write,
	output logic [3:0] byteenable,
	output logic [31:0] writedata
);
	// Idle bus at time zero
	initial begin
		address = 4'hf;
		read = 1'b0;
		write = 1'b0;
		byteenable = 4'h0;
		writedata = 32'h0;
	end

	// Request held until waitrequest is seen low at a rising edge
	task automatic access(input logic [3:0] a, input logic wr, input logic [3:0] be,
		input logic [31:0] d);
		address <= a;
		read <= !wr;
		write <= wr;
		byteenable <= be;
		writedata <= d;
		@(posedge clk);
		while (waitrequest !== 1'b0) @(posedge clk);
		// Released lines change, so a stale value is never trusted
		read <= 1'b0;
		write <= 1'b0;
		address <= ~a;
		writedata <= ~d;
		@(posedge clk);
	endtask
endmodule

// >>> sim/uart_irq_status_line_format_bench.sv
// Self-checking bench for the interrupt identity and line format block
`timescale 1ns/10ps
`define CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin error_cnt++; \
	$display("wrong value at %0t: got %h expected %h", $time, got, exp); end end
module uart_irq_status_line_format_bench;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [3:0] address;
	logic [3:0] byteenable;
	logic read;
	logic write;
	logic waitrequest;
	logic [31:0] writedata;
	logic [31:0] readdata;
	uart_fmt_pkg::irq_src_t irq_src;
	uart_fmt_pkg::line_fmt_t fmt;
	uart_fmt_pkg::line_fmt_t e;
	logic tx_serial = 1'b1;
	logic tx_line;
	logic [7:0] tx_char;
	logic [7:0] v;
	logic [7:0] m;
	logic [7:0] c;
	logic [31:0] seed = 32'hfd844a2c;
	logic [31:0] exp_q[$];
	logic [31:0] nx;
	logic brk = 1'b0;
	logic tx_chk = 1'b0;
	logic ts_prev = 1'b1;
	logic [7:0] codes[5] = '{8'h06, 8'h04, 8'h0c, 8'h02, 8'h00};
	int error_cnt = 0;
	int cmp_count = 0;
	int cyc = 0;

	always #10 clk = ~clk;

	avalon_host i_avalon_host (.clk(clk), .waitrequest(waitrequest), .address(address),
		.read(read), .write(write), .byteenable(byteenable), .writedata(writedata));

	uart_status_format i_uart_status_format (.clk(clk), .reset_n(reset_n),
		.address(address), .read(read), .write(write), .byteenable(byteenable),
		.writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
		.irq_src(irq_src), .tx_serial(tx_serial), .tx_char(tx_char), .tx_line(tx_line),
		.fmt(fmt));

	task automatic results();
		$display("errors %0d comparisons %0d", error_cnt, cmp_count);
		if (error_cnt == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// Upper write lanes carry noise the block must ignore
	task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [3:0] be = 4'h1);
		logic [31:0] r;
		r = $random(seed);
		i_avalon_host.access(a, 1'b1, be, {r[31:8], d});
	endtask

	task automatic rd(input logic [3:0] a, input logic [7:0] x);
		exp_q.push_back({24'h0, x});
		i_avalon_host.access(a, 1'b0, 4'h1, 32'h0);
	endtask

	task automatic irq(input logic [4:0] s, input logic [7:0] x);
		irq_src <= s;
		repeat (2) @(posedge clk);
		rd(uart_fmt_pkg::OFS_IDENT, x);
	endtask

	// Read results are compared against the oldest note
	always @(posedge clk) begin
		if (read && waitrequest === 1'b0) begin
			nx = exp_q.pop_front();
			`CHK(readdata, nx)
		end
	end

	// Serial pin follows the transmitter one edge late unless breaking
	always @(posedge clk) begin
		if (tx_chk) `CHK(tx_line, brk ? 1'b0 : ts_prev)
		ts_prev <= tx_serial;
		tx_serial <= 1'($random(seed));
	end

	// Hang guard
	always @(posedge clk) begin
		cyc++;
		if (cyc > 4000) begin
			error_cnt++;
			results();
		end
	end

	initial begin
		irq_src = '0;
		tx_char = 8'h00;
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		tx_chk <= 1'b1;
		rd(uart_fmt_pkg::OFS_IDENT, 8'h01);
		rd(uart_fmt_pkg::OFS_LINE, 8'h00);
		`CHK(fmt, {4'h5, 3'h2, 3'h0})
		for (int i = 0; i < 5; i++) irq(5'h10 >> i, codes[i]);
		irq(5'h00, 8'h01);
		irq(5'h1f, 8'h06);
		irq(5'h0c, 8'h04);
		irq(5'h00, 8'h01);
		irq(5'h01, 8'h00);
		irq(5'h11, 8'h00);
		irq(5'h10, 8'h06);
		irq(5'h00, 8'h01);
		wr(uart_fmt_pkg::OFS_FIFO, 8'h01);
		rd(uart_fmt_pkg::OFS_FIFO, 8'h01);
		rd(uart_fmt_pkg::OFS_IDENT, 8'hc1);
		irq(5'h02, 8'hc2);
		irq(5'h00, 8'hc1);
		wr(uart_fmt_pkg::OFS_FIFO, 8'h00);
		rd(uart_fmt_pkg::OFS_IDENT, 8'h01);
		// Refused writes: read-only, lane disabled, unmapped
		wr(uart_fmt_pkg::OFS_IDENT, 8'hfe);
		rd(uart_fmt_pkg::OFS_IDENT, 8'h01);
		wr(uart_fmt_pkg::OFS_LINE, 8'h3f, 4'h0);
		rd(uart_fmt_pkg::OFS_LINE, 8'h00);
		wr(4'hc, 8'hff);
		rd(4'hc, 8'h00);
		// Every parity, stop and length code, divisor bit at random
		for (int i = 0; i < 64; i++) begin
			c = 8'($random(seed));
			v = {c[7], 1'b0, i[5:0]};
			c = 8'($random(seed));
			tx_char <= c;
			wr(uart_fmt_pkg::OFS_LINE, v);
			rd(uart_fmt_pkg::OFS_LINE, v);
			m = c & (8'hff >> (2'h3 - v[1:0]));
			e.word_bits = 4'h5 + {2'h0, v[1:0]};
			e.stop_halves = !v[2] ? 3'h2 : (v[1:0] == 2'h0 ? 3'h3 : 3'h4);
			e.parity_en = v[3];
			e.parity_bit = !v[3] ? 1'b0 : v[5:4] == 2'h0 ? ~^m : v[5:4] == 2'h1 ? ^m : !v[4];
			e.divisor_access = v[7];
			`CHK(fmt, e)
		end
		// Break holds the pin low until cleared
		tx_chk <= 1'b0;
		wr(uart_fmt_pkg::OFS_LINE, 8'h40);
		brk <= 1'b1;
		tx_chk <= 1'b1;
		repeat (20) @(posedge clk);
		rd(uart_fmt_pkg::OFS_LINE, 8'h40);
		tx_chk <= 1'b0;
		wr(uart_fmt_pkg::OFS_LINE, 8'h00);
		brk <= 1'b0;
		tx_chk <= 1'b1;
		repeat (20) @(posedge clk);
		// Mid-run reset clears format, break and FIFO indication
		tx_chk <= 1'b0;
		wr(uart_fmt_pkg::OFS_FIFO, 8'h01);
		wr(uart_fmt_pkg::OFS_LINE, 8'hdb);
		reset_n <= 1'b0;
		repeat (2) @(posedge clk);
		reset_n <= 1'b1;
		repeat (2) @(posedge clk);
		tx_chk <= 1'b1;
		rd(uart_fmt_pkg::OFS_LINE, 8'h00);
		rd(uart_fmt_pkg::OFS_IDENT, 8'h01);
		`CHK(fmt, {4'h5, 3'h2, 3'h0})
		repeat (20) @(posedge clk);
		results();
	end
endmodule
